// *** src/boot_link_params.svh ***
// constants for the boot sequencer and link command port
`ifndef BOOT_LINK_PARAMS_SVH
`define BOOT_LINK_PARAMS_SVH
`define REG_CLOCK_SPEED_DIVIDER 16'hc008
`define REG_GLOBAL_INTERRUPT_ENABLE 16'hc00e
`define REG_EXTENDED_WINDOW_LOW_PAGE 16'hc018
`define REG_EXTENDED_WINDOW_HIGH_PAGE 16'hc01a
`define REG_EXTERNAL_MEMORY_CONTROL 16'hc03a
`define REG_BOOT_STATUS 16'hc0f0
`define REG_LINK_COMMAND 16'hc0f2
`define REG_LINK_RESPONSE 16'hc0f4
`define REG_LINK_STATUS 16'hc0f6
`define SPEED_RESET 16'h000f
`define PC_RESET 16'hff00
`define ROM_ENTRY 16'he000
`define STACK_INIT 16'h0400
`define EMC_POWER_UP 16'h27f7
`define EMC_FIVE_WAIT 16'h2777
`define EMC_8BIT_BIT 7
`define EMC_WAIT_LSB 4
`define ROM_SIG_ADDR 16'hc100
`define ROM_JUMP_ADDR 16'hc102
`define SIG_DIRECT 16'hcb36
`define SIG_SCAN 16'hc3b6
`define SIG_SCAN_LOW 8'hb6
`define RAM_PROBE_ADDR 16'h6000
`define RAM_PROBE_PATTERN 16'ha55a
`define WAIT_STATE_PS 20800
`define CLOCK_PERIOD_PS 8000
`define WAIT_STATE_CYCLES ((`WAIT_STATE_PS + `CLOCK_PERIOD_PS - 1) / `CLOCK_PERIOD_PS)
`define CODE_ACCEPTED 16'h0fed
`define CODE_REFUSED 16'hdead
`define CMD_PORT_CONFIGURE 16'hce0c
`define CMD_MEMORY_READ 16'hce0a
`define CMD_MEMORY_WRITE 16'hce0b
`define CMD_XMEM_READ 16'hce0d
`define CMD_XMEM_WRITE 16'hce0e
`define CMD_USB_ENABLE 16'hce10
`define MAX_TRANSFER_BYTES 2048
`define SETTLE_US 30
`define SETTLE_BAUD_US 100
`define CYCLES_PER_US 125
`endif

// *** src/boot_link_pkg.sv ***
// types used by the device end of the link
`default_nettype none
package boot_link_pkg;
    typedef enum logic [1:0] {
        port_parallel = 2'h0,
        port_serial_fast = 2'h1,
        port_serial_periph = 2'h2,
        port_eeprom = 2'h3
    } boot_port_t;
endpackage : boot_link_pkg
`default_nettype wire

// *** src/boot_link_if.sv ***
// link between master processor and device: memory bus, mailbox, straps
`default_nettype none
interface boot_link_if;
    logic mem_req;
    logic mem_we;
    logic mem_byte;
    logic [15:0] mem_addr;
    logic [15:0] mem_wdata;
    logic [15:0] mem_rdata;
    logic mem_done;
    logic [1:0] boot_strap;
    logic otg_identification_pin;
    logic cmd_valid;
    logic [15:0] cmd_word;
    logic [15:0] cmd_len;
    logic rsp_valid;
    logic [15:0] rsp_word;
    logic boot_done;
    modport device (
        output mem_req, mem_we, mem_byte, mem_addr, mem_wdata,
        input mem_rdata, mem_done, boot_strap, otg_identification_pin,
        input cmd_valid, cmd_word, cmd_len,
        output rsp_valid, rsp_word, boot_done
    );
    modport master (
        input mem_req, mem_we, mem_byte, mem_addr, mem_wdata,
        output mem_rdata, mem_done, boot_strap, otg_identification_pin,
        output cmd_valid, cmd_word, cmd_len,
        input rsp_valid, rsp_word, boot_done
    );
endinterface : boot_link_if
`default_nettype wire

// *** src/link_master_end.sv ***
// master processor end: posts one command, waits for reply, then settles
`include "boot_link_params.svh"
`default_nettype none
module link_master_end #(
    parameter int SETTLE_CYCLES = `SETTLE_US * `CYCLES_PER_US,
    parameter int BAUD_CYCLES = `SETTLE_BAUD_US * `CYCLES_PER_US
) (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_enable,
    input wire logic [1:0] i_boot_strap,
    input wire logic i_otg_id,
    input wire logic i_cmd_go,
    input wire logic [15:0] i_cmd_word,
    input wire logic [15:0] i_cmd_len,
    input wire logic [15:0] i_mem_rdata,
    input wire logic i_mem_done,
    output logic o_busy,
    output logic [15:0] o_reply,
    output logic o_reply_valid,
    output logic o_refused_local,
    boot_link_if.master link
);
    logic pending_ff;
    logic [15:0] cmd_ff;
    logic [15:0] len_ff;
    logic [13:0] settle_ff;
    logic oversize;
    assign oversize = i_cmd_len > 16'(`MAX_TRANSFER_BYTES);
    assign link.boot_strap = i_boot_strap;
    assign link.otg_identification_pin = i_otg_id;
    assign link.mem_rdata = i_mem_rdata;
    assign link.mem_done = i_mem_done;
    assign link.cmd_word = cmd_ff;
    assign link.cmd_len = len_ff;
    assign o_busy = pending_ff | (settle_ff != 14'h0) | ~link.boot_done;
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            pending_ff <= 1'b0;
            cmd_ff <= 16'h0;
            len_ff <= 16'h0;
            link.cmd_valid <= 1'b0;
            o_refused_local <= 1'b0;
        end else if (i_enable) begin
            link.cmd_valid <= 1'b0;
            o_refused_local <= 1'b0;
            if (i_cmd_go && !o_busy) begin
                if (oversize) begin
                    o_refused_local <= 1'b1;
                end else begin
                    pending_ff <= 1'b1;
                    cmd_ff <= i_cmd_word;
                    len_ff <= i_cmd_len;
                    link.cmd_valid <= 1'b1;
                end
            end else if (pending_ff && link.rsp_valid) begin
                pending_ff <= 1'b0;
            end
        end
    end
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            settle_ff <= 14'h0;
            o_reply <= 16'h0;
            o_reply_valid <= 1'b0;
        end else if (i_enable) begin
            o_reply_valid <= 1'b0;
            if (pending_ff && link.rsp_valid) begin
                o_reply <= link.rsp_word;
                o_reply_valid <= 1'b1;
                settle_ff <= (cmd_ff == `CMD_PORT_CONFIGURE) ? 14'(BAUD_CYCLES)
                                                             : 14'(SETTLE_CYCLES);
            end else if (settle_ff != 14'h0) begin
                settle_ff <= settle_ff - 14'h1;
            end
        end
    end
endmodule : link_master_end
`default_nettype wire

// *** src/boot_link_device.sv ***
// device end: start-up sequencer, strap decode and single command port
//
// Contract
// - memory regions 8/16 bit, 0-7 waits
// - each wait adds one 20.8 ns period; the code adds three 8 ns clocks (24 ns)
// - memory control powers up to 0x27f7
// - reset divider 0x000f, program counter 0xff00
// - jump e000, stack 400, divider zero, irq off
// - then memory control gets 0x2777
// - signature cb36 at c100 jumps c102
// - low byte b6 sets 8-bit bit; the code skips it when the high byte is c3
// - no signature: small variant rom pins gpio
// - low page gets 0, high gets 1
// - probe ram at 6000, set width
// - run scan on c3b6, then idle
// - identification pin picks first engine role
// - straps pick parallel, serial, peripheral, eeprom
// - co-processor: usb ports off until commanded
// - stand-alone: debug peripheral, first by pin
// - one command at a time, no queue
// - one 16-bit word command and reply
// - master: operands, post, poll, reply, data
// - serial command is 8-byte packet
// - transfers limited to 2048 bytes
// - master waits 30 or 100 us
`include "boot_link_params.svh"
`default_nettype none
module boot_link_device #(
    parameter bit REDUCED_PIN = 1'b0
) (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_enable,
    input wire logic [15:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_write,
    input wire logic i_read,
    output logic [15:0] o_rdata,
    output logic [15:0] o_program_counter,
    output logic [15:0] o_stack_pointer,
    output logic o_rom_pins_gpio,
    output logic o_scan_run,
    output logic o_usb_first_host,
    output logic o_usb_first_on,
    output logic o_usb_debug_on,
    boot_link_if.device link
);
    typedef enum logic [9:0] {
        st_reset = 10'h001, st_entry = 10'h002, st_emc = 10'h004,
        st_sig16 = 10'h008, st_sig8 = 10'h010, st_ram_wr = 10'h020,
        st_ram_rd = 10'h040, st_setup = 10'h080, st_idle = 10'h100,
        st_exec = 10'h200
    } state_t;
    state_t state_ff;
    state_t nxt_state;
    logic [15:0] speed_ff;
    logic [15:0] gie_ff;
    logic [15:0] page_low_ff;
    logic [15:0] page_high_ff;
    logic [15:0] emc_ff;
    logic [15:0] sig_ff;
    logic [1:0] strap_ff;
    logic [2:0] wait_cnt_ff;
    logic [1:0] sub_cnt_ff;
    logic mem_go;
    logic mem_fin;
    logic [2:0] waits;
    logic fast_port;
    assign waits = emc_ff[`EMC_WAIT_LSB +: 3];
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            st_reset: nxt_state = st_entry;
            st_entry: nxt_state = st_emc;
            st_emc: nxt_state = st_sig16;
            st_sig16: if (mem_fin) nxt_state = (link.mem_rdata == `SIG_DIRECT) ? st_idle : st_sig8;
            st_sig8: if (mem_fin) nxt_state = st_ram_wr;
            st_ram_wr: if (mem_fin) nxt_state = st_ram_rd;
            st_ram_rd: if (mem_fin) nxt_state = st_setup;
            st_setup: nxt_state = st_idle;
            st_idle: if (link.cmd_valid) nxt_state = st_exec;
            st_exec: nxt_state = st_idle;
            default: nxt_state = st_reset;
        endcase
    end
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) state_ff <= st_reset;
        else if (i_enable) state_ff <= nxt_state;
    end
    // external memory cycle, stretched by programmed waits
    assign mem_go = state_ff inside {st_sig16, st_sig8, st_ram_wr, st_ram_rd};
    assign mem_fin = mem_go && link.mem_done && (wait_cnt_ff == waits)
                     && (sub_cnt_ff == 2'(`WAIT_STATE_CYCLES - 1));
    // counters freeze with the rest of the state while enable is low
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            wait_cnt_ff <= 3'h0;
            sub_cnt_ff <= 2'h0;
        end else if (i_enable) begin
            if (!mem_go || mem_fin) begin
                wait_cnt_ff <= 3'h0;
                sub_cnt_ff <= 2'h0;
            end else if (wait_cnt_ff != waits) begin
                if (sub_cnt_ff == 2'(`WAIT_STATE_CYCLES - 1)) begin
                    sub_cnt_ff <= 2'h0;
                    wait_cnt_ff <= wait_cnt_ff + 3'h1;
                end else begin
                    sub_cnt_ff <= sub_cnt_ff + 2'h1;
                end
            end else begin
                sub_cnt_ff <= (sub_cnt_ff == 2'(`WAIT_STATE_CYCLES - 1)) ? sub_cnt_ff
                                                                          : sub_cnt_ff + 2'h1;
            end
        end
    end
    always_comb begin
        link.mem_req = mem_go;
        link.mem_we = (state_ff == st_ram_wr);
        link.mem_byte = (state_ff == st_sig8) | emc_ff[`EMC_8BIT_BIT];
        link.mem_addr = (state_ff inside {st_ram_wr, st_ram_rd}) ? `RAM_PROBE_ADDR
                                                                  : `ROM_SIG_ADDR;
        link.mem_wdata = `RAM_PROBE_PATTERN;
    end
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            o_program_counter <= `PC_RESET;
            o_stack_pointer <= 16'h0;
            speed_ff <= `SPEED_RESET;
            gie_ff <= 16'h0;
            emc_ff <= `EMC_POWER_UP;
            page_low_ff <= 16'h0;
            page_high_ff <= 16'h0;
            sig_ff <= 16'h0;
            o_rom_pins_gpio <= 1'b0;
            o_scan_run <= 1'b0;
        end else if (i_enable) begin
            case (state_ff)
                st_entry: begin
                    o_program_counter <= `ROM_ENTRY;
                    o_stack_pointer <= `STACK_INIT;
                    speed_ff <= 16'h0;
                    gie_ff <= 16'h0;
                end
                st_emc: emc_ff <= `EMC_FIVE_WAIT;
                st_sig16: if (mem_fin) begin
                    sig_ff <= link.mem_rdata;
                    if (link.mem_rdata == `SIG_DIRECT)
                        o_program_counter <= `ROM_JUMP_ADDR;
                end
                st_sig8: if (mem_fin) begin
                    if (link.mem_rdata[7:0] == `SIG_SCAN_LOW && link.mem_rdata[15:8] != 8'hc3)
                        emc_ff[`EMC_8BIT_BIT] <= 1'b1;
                    if (REDUCED_PIN && sig_ff != `SIG_SCAN && link.mem_rdata[7:0] != `SIG_SCAN_LOW)
                        o_rom_pins_gpio <= 1'b1;
                    page_low_ff <= 16'h0;
                    page_high_ff <= 16'h1;
                end
                st_ram_rd: if (mem_fin && link.mem_rdata != `RAM_PROBE_PATTERN)
                    emc_ff[`EMC_8BIT_BIT] <= 1'b1;
                st_setup: begin
                    gie_ff <= 16'h0;
                    o_scan_run <= (sig_ff == `SIG_SCAN);
                end
                default: begin
                    // software writes; later write wins
                    if (i_write && i_addr == `REG_CLOCK_SPEED_DIVIDER) speed_ff <= i_wdata;
                    if (i_write && i_addr == `REG_GLOBAL_INTERRUPT_ENABLE) gie_ff <= i_wdata;
                    if (i_write && i_addr == `REG_EXTENDED_WINDOW_LOW_PAGE) page_low_ff <= i_wdata;
                    if (i_write && i_addr == `REG_EXTENDED_WINDOW_HIGH_PAGE)
                        page_high_ff <= i_wdata;
                    if (i_write && i_addr == `REG_EXTERNAL_MEMORY_CONTROL)
                        emc_ff <= i_wdata;
                end
            endcase
        end
    end
    // straps caught once, after reset release
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) strap_ff <= 2'h0;
        else if (i_enable && state_ff == st_reset) strap_ff <= link.boot_strap;
    end
    assign fast_port = strap_ff == boot_link_pkg::port_serial_fast;
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            o_usb_first_host <= 1'b0;
            o_usb_first_on <= 1'b0;
            o_usb_debug_on <= 1'b0;
            link.rsp_valid <= 1'b0;
            link.rsp_word <= 16'h0;
        end else if (i_enable) begin
            link.rsp_valid <= 1'b0;
            if (state_ff == st_setup) begin
                o_usb_first_host <= ~link.otg_identification_pin;
                o_usb_first_on <= (strap_ff == boot_link_pkg::port_eeprom);
                o_usb_debug_on <= (strap_ff == boot_link_pkg::port_eeprom);
            end
            if (state_ff == st_exec) begin
                link.rsp_valid <= 1'b1;
                if (strap_ff == boot_link_pkg::port_eeprom ||
                    (fast_port && link.cmd_len > 16'(`MAX_TRANSFER_BYTES))) begin
                    link.rsp_word <= `CODE_REFUSED;
                end else begin
                    link.rsp_word <= `CODE_ACCEPTED;
                    if (link.cmd_word == `CMD_USB_ENABLE) begin
                        o_usb_first_on <= 1'b1;
                        o_usb_debug_on <= 1'b1;
                    end
                end
            end
        end
    end
    assign link.boot_done = (state_ff == st_idle) | (state_ff == st_exec);
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) o_rdata <= 16'h0;
        else if (i_enable && i_read) begin
            case (i_addr)
                `REG_CLOCK_SPEED_DIVIDER: o_rdata <= speed_ff;
                `REG_GLOBAL_INTERRUPT_ENABLE: o_rdata <= gie_ff;
                `REG_EXTENDED_WINDOW_LOW_PAGE: o_rdata <= page_low_ff;
                `REG_EXTENDED_WINDOW_HIGH_PAGE: o_rdata <= page_high_ff;
                `REG_EXTERNAL_MEMORY_CONTROL: o_rdata <= emc_ff;
                `REG_BOOT_STATUS: o_rdata <= {4'h0, state_ff, strap_ff};
                default: o_rdata <= 16'h0;
            endcase
        end
    end
endmodule : boot_link_device
`default_nettype wire

// *** tb/boot_link_props.sv ***
// concurrent checks on the link between master end and device end
`include "boot_link_params.svh"
`default_nettype none
module boot_link_props (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic mem_req,
    input wire logic mem_done,
    input wire logic [15:0] mem_addr,
    input wire logic [1:0] boot_strap,
    input wire logic cmd_valid,
    input wire logic [15:0] cmd_word,
    input wire logic [15:0] cmd_len,
    input wire logic rsp_valid,
    input wire logic [15:0] rsp_word,
    input wire logic boot_done
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);
    sequence s_reply;
        ##2 rsp_valid ##1 !rsp_valid;
    endsequence
    sequence s_quiet;
        !cmd_valid [*4];
    endsequence
    a_reply_timing: assert property (cmd_valid |-> s_reply)
        else $error("reply missing two cycles after command");
    a_reply_asked: assert property (rsp_valid |-> $past(cmd_valid, 2))
        else $error("reply without a command");
    a_single_command: assert property (cmd_valid |=> s_quiet)
        else $error("second command while one outstanding");
    a_boot_first: assert property (cmd_valid |-> boot_done)
        else $error("command posted during start-up");
    a_length_cap: assert property (cmd_valid |-> cmd_len <= `MAX_TRANSFER_BYTES)
        else $error("oversized transfer sent to device");
    a_eeprom_refused: assert property (
        rsp_valid && boot_strap == 2'h3 |-> rsp_word == `CODE_REFUSED)
        else $error("stand-alone device accepted a command");
    a_config_acked: assert property (rsp_valid && boot_strap != 2'h3
        && $past(cmd_word, 2) == `CMD_PORT_CONFIGURE |-> rsp_word == `CODE_ACCEPTED)
        else $error("configure not acknowledged");
    a_reply_stands: assert property (!rsp_valid |-> $stable(rsp_word))
        else $error("reply word changed between replies");
    a_memory_held: assert property (mem_req && !mem_done |=> mem_req && $stable(mem_addr))
        else $error("memory cycle dropped before done");
endmodule : boot_link_props
`default_nettype wire

// *** tb/boot_and_link_command_port_bench.sv ***
// bench: start-up per strap setting, then link commands through the master end
`include "boot_link_params.svh"
`default_nettype none
module boot_and_link_command_port_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SETTLE_SHORT = 10;
    localparam int SETTLE_LONG = 20;
    localparam logic [1:0] STRAPS [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
    localparam logic OTGS [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    localparam logic [15:0] ROMS [5] = '{`SIG_DIRECT, `SIG_SCAN, 16'h0000,
        {8'h00, `SIG_SCAN_LOW}, 16'h0000};
    logic i_clock = 1'b0;
    logic i_reset_n = 1'b0;
    logic [15:0] i_addr = 16'h0000;
    logic [15:0] i_wdata = 16'h0000;
    logic i_write = 1'b0;
    logic i_read = 1'b0;
    logic [1:0] strap = 2'h0;
    logic otg = 1'b0;
    logic cmd_go = 1'b0;
    logic [15:0] cmd_word = 16'h0000;
    logic [15:0] cmd_len = 16'h0000;
    logic [15:0] mem_rdata = 16'h0000;
    logic mem_done = 1'b0;
    logic [16:0] last_key = 17'h00000;
    logic [15:0] rom_word = 16'h0000;
    logic [15:0] ram_word = 16'h0000;
    logic [15:0] o_rdata, pc, sp, reply, r;
    logic rom_gpio, scan_run, first_host, first_on, debug_on, busy, reply_valid, refused, rf;
    logic small_gpio;
    int settle;
    int n_mismatch = 0;
    int n_tests = 0;
    boot_link_if link_bus ();
    boot_link_device boot_link_device_inst (.i_clock(i_clock), .i_reset_n(i_reset_n),
        .i_enable(1'b1), .i_addr(i_addr), .i_wdata(i_wdata), .i_write(i_write),
        .i_read(i_read), .o_rdata(o_rdata), .o_program_counter(pc), .o_stack_pointer(sp),
        .o_rom_pins_gpio(rom_gpio), .o_scan_run(scan_run), .o_usb_first_host(first_host),
        .o_usb_first_on(first_on), .o_usb_debug_on(debug_on), .link(link_bus));
    link_master_end #(.SETTLE_CYCLES(SETTLE_SHORT), .BAUD_CYCLES(SETTLE_LONG))
        link_master_end_inst (
        .i_clock(i_clock), .i_reset_n(i_reset_n), .i_enable(1'b1), .i_boot_strap(strap),
        .i_otg_id(otg), .i_cmd_go(cmd_go), .i_cmd_word(cmd_word), .i_cmd_len(cmd_len),
        .i_mem_rdata(mem_rdata), .i_mem_done(mem_done), .o_busy(busy), .o_reply(reply),
        .o_reply_valid(reply_valid), .o_refused_local(refused), .link(link_bus));
    boot_link_props boot_link_props_inst (.i_clock(i_clock), .i_reset_n(i_reset_n),
        .mem_req(link_bus.mem_req), .mem_done(link_bus.mem_done),
        .mem_addr(link_bus.mem_addr), .boot_strap(link_bus.boot_strap),
        .cmd_valid(link_bus.cmd_valid), .cmd_word(link_bus.cmd_word),
        .cmd_len(link_bus.cmd_len), .rsp_valid(link_bus.rsp_valid),
        .rsp_word(link_bus.rsp_word), .boot_done(link_bus.boot_done));
    // reduced-pin twin runs in step with the full device off the same memory and master
    boot_link_if small_bus ();
    assign small_bus.mem_rdata = link_bus.mem_rdata;
    assign small_bus.mem_done = link_bus.mem_done;
    assign small_bus.boot_strap = link_bus.boot_strap;
    assign small_bus.otg_identification_pin = link_bus.otg_identification_pin;
    assign small_bus.cmd_valid = link_bus.cmd_valid;
    assign small_bus.cmd_word = link_bus.cmd_word;
    assign small_bus.cmd_len = link_bus.cmd_len;
    boot_link_device #(.REDUCED_PIN(1'b1)) boot_link_device_small_inst (.i_clock(i_clock),
        .i_reset_n(i_reset_n), .i_enable(1'b1), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_write(i_write), .i_read(i_read), .o_rdata(), .o_program_counter(),
        .o_stack_pointer(), .o_rom_pins_gpio(small_gpio), .o_scan_run(),
        .o_usb_first_host(), .o_usb_first_on(), .o_usb_debug_on(), .link(small_bus));
    initial begin
        forever #4 i_clock = ~i_clock;
    end
    // done waits one cycle on a new access, so a stale done never ends it
    always @(posedge i_clock) begin
        mem_done <= link_bus.mem_req && last_key == {link_bus.mem_we, link_bus.mem_addr};
        last_key <= link_bus.mem_req ? {link_bus.mem_we, link_bus.mem_addr} : 17'h1ffff;
        if (link_bus.mem_req && link_bus.mem_we && link_bus.mem_addr == `RAM_PROBE_ADDR) begin
            ram_word <= link_bus.mem_wdata;
        end
        if (link_bus.mem_addr == `ROM_SIG_ADDR) begin
            mem_rdata <= rom_word;
        end else if (link_bus.mem_addr == `RAM_PROBE_ADDR) begin
            mem_rdata <= ram_word;
        end else begin
            mem_rdata <= ~mem_rdata;
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        n_tests++;
        if (seen !== want) begin
            n_mismatch++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask : check
    task automatic reg_write(input logic [15:0] a, input logic [15:0] d);
        @(posedge i_clock);
        i_addr <= a;
        i_wdata <= d;
        i_write <= 1'b1;
        @(posedge i_clock);
        i_write <= 1'b0;
    endtask : reg_write
    task automatic rd_check(input logic [15:0] a, input logic [15:0] want);
        @(posedge i_clock);
        i_addr <= a;
        i_read <= 1'b1;
        @(posedge i_clock);
        i_read <= 1'b0;
        #1;
        check(o_rdata, want);
    endtask : rd_check
    task automatic send_cmd(input logic [15:0] w, input logic [15:0] l, output logic [15:0] rv,
        output logic rl, output int st);
        int k;
        @(posedge i_clock);
        cmd_word <= w;
        cmd_len <= l;
        cmd_go <= 1'b1;
        @(posedge i_clock);
        cmd_go <= 1'b0;
        #1;
        k = 0;
        while (reply_valid !== 1'b1 && refused !== 1'b1 && k < 50) begin
            @(posedge i_clock);
            #1;
            k++;
        end
        // a reply that never comes must not pass on a stale one
        if (k == 50) n_mismatch++;
        rv = reply;
        rl = refused;
        k = 0;
        while (busy !== 1'b0 && k < 300) begin
            @(posedge i_clock);
            #1;
            k++;
        end
        if (k == 300) n_mismatch++;
        st = k;
    endtask : send_cmd
    task automatic final_report();
        $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (30000) @(posedge i_clock);
        n_mismatch++;
        final_report();
    end
    initial begin
        for (int i = 0; i < 5; i++) begin
            @(posedge i_clock);
            i_reset_n <= 1'b0;
            strap <= STRAPS[i];
            otg <= OTGS[i];
            rom_word <= ROMS[i];
            repeat (16) @(posedge i_clock);
            #1;
            check(pc, `PC_RESET);
            @(posedge i_clock);
            i_reset_n <= 1'b1;
            for (int k = 0; k < 4000 && link_bus.boot_done !== 1'b1; k++) begin
                @(posedge i_clock);
                #1;
            end
            check({15'h0000, link_bus.boot_done}, 16'h0001);
            check(sp, `STACK_INIT);
            rd_check(`REG_CLOCK_SPEED_DIVIDER, 16'h0000);
            rd_check(`REG_GLOBAL_INTERRUPT_ENABLE, 16'h0000);
            rd_check(`REG_EXTENDED_WINDOW_LOW_PAGE, 16'h0000);
            rd_check(`REG_EXTENDED_WINDOW_HIGH_PAGE, {15'h0000, i != 0});
            rd_check(`REG_EXTERNAL_MEMORY_CONTROL,
                (i == 3) ? (`EMC_FIVE_WAIT | 16'h0080) : `EMC_FIVE_WAIT);
            check(pc, (i == 0) ? `ROM_JUMP_ADDR : `ROM_ENTRY);
            check({15'h0000, scan_run}, {15'h0000, i == 1});
            check({15'h0000, debug_on}, {15'h0000, i >= 3});
            check({15'h0000, first_on}, {15'h0000, i >= 3});
            check({15'h0000, rom_gpio}, 16'h0000);
            check({15'h0000, small_gpio}, {15'h0000, i == 2 || i == 4});
            if (i >= 3) begin
                check({15'h0000, first_host}, {15'h0000, !OTGS[i]});
            end
            send_cmd(`CMD_PORT_CONFIGURE, 16'h0000, r, rf, settle);
            check(r, (i >= 3) ? `CODE_REFUSED : `CODE_ACCEPTED);
            check(16'(settle), 16'(SETTLE_LONG));
            if (i == 1) begin
                send_cmd(`CMD_PORT_CONFIGURE, 16'd2049, r, rf, settle);
                check({15'h0000, rf}, 16'h0001);
                send_cmd(`CMD_MEMORY_READ, 16'd2048, r, rf, settle);
                check({15'h0000, rf}, 16'h0000);
                check(16'(settle), 16'(SETTLE_SHORT));
                send_cmd(`CMD_USB_ENABLE, 16'h0000, r, rf, settle);
                check(r, `CODE_ACCEPTED);
                check({15'h0000, first_on}, 16'h0001);
                reg_write(`REG_EXTERNAL_MEMORY_CONTROL, 16'h2737);
                reg_write(`REG_EXTERNAL_MEMORY_CONTROL, 16'h2717);
                rd_check(`REG_EXTERNAL_MEMORY_CONTROL, 16'h2717);
            end
        end
        final_report();
    end
endmodule : boot_and_link_command_port_bench
`default_nettype wire
